// ### hw/ir_codec.sv
`timescale 1ns/1ps
module ir_codec
    import pins_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Async reset
    input wire logic ir_mode, // Infrared select
    input wire logic tick, // 16x bit-rate enable
    input wire logic tx_bit, // Transmit shifter bit
    input wire logic line_in, // Receive pin
    output logic line_out, // Transmit pin
    output logic rx_bit // Bit to receiver
);
    codec_state_type q, d;

    always_comb begin
        d = q;
        d.prev_tx = tx_bit;
        if (tx_bit != q.prev_tx) begin
            d.phase = 4'h0;
        end else if (tick) begin
            d.phase = q.phase + 4'h1;
        end
        if (!ir_mode) begin
            d.stretch = 4'h0;
            d.line_out = tx_bit; // see (R1)
            d.rx_bit = line_in; // see (R3)
        end else begin
            if (line_in) begin
                d.stretch = IR_STRETCH_TICKS;
            end else if (tick && q.stretch != 4'h0) begin
                d.stretch = q.stretch - 4'h1;
            end
            // Short high pulse per zero bit, low when idle
            d.line_out = !tx_bit && (d.phase < IR_PULSE_TICKS); // see (R2)
            d.rx_bit = (d.stretch == 4'h0); // see (R2)
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= CODEC_RESET; // see (R12)
        end else begin
            q <= d;
        end
    end

    assign line_out = q.line_out;
    assign rx_bit = q.rx_bit;
endmodule

// ### hw/modem_lines.sv
`timescale 1ns/1ps
module modem_lines
    import pins_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Async reset
    input wire chan_ctrl_type ctrl, // Channel control registers
    input wire modem_in_type modem_in, // Modem input pins
    input wire logic rx_halt, // Receive FIFO above trigger
    input wire logic rx_avail, // Receive data available
    output lines_state_type lines // Registered pin state and events
);
    lines_state_type q, d;
    logic auto_rts;
    logic auto_cts;

    assign auto_rts = ctrl.enhanced_feature[EFR_AUTO_RTS_BIT];
    assign auto_cts = ctrl.enhanced_feature[EFR_AUTO_CTS_BIT];

    always_comb begin
        d = q;
        d.prev = modem_in;
        // Auto flow control only lifts an asserted request line
        d.rts_n = !ctrl.modem_control[MCR_RTS_BIT] || (auto_rts && rx_halt); // see (R7)
        d.dtr_n = !ctrl.modem_control[MCR_DTR_BIT]; // see (R10)
        d.op2_n = !ctrl.modem_control[MCR_AUX_BIT]; // see (R4) see (R5)
        d.irq_oe = ctrl.modem_control[MCR_AUX_BIT]; // see (R4) see (R5)
        d.tx_en = !(auto_cts && modem_in.cts_n); // see (R8) see (R9)
        d.rdy_n = !rx_avail; // see (R11)
        d.ev[EV_CTS] = q.prev.cts_n ^ modem_in.cts_n;
        d.ev[EV_DSR] = q.prev.dsr_n ^ modem_in.dsr_n; // see (R9)
        d.ev[EV_CD] = q.prev.cd_n ^ modem_in.cd_n; // see (R9)
        d.ev[EV_RI] = !q.prev.ri_n && modem_in.ri_n; // see (R9)
        d.ev[EV_CTS_STOP] = auto_cts && ctrl.interrupt_enable[IER_CTS_BIT] &&
                            !q.prev.cts_n && modem_in.cts_n; // see (R8)
        d.ev[EV_RTS_STOP] = auto_rts && ctrl.interrupt_enable[IER_RTS_BIT] && !q.rts_n && d.rts_n;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= LINES_RESET; // see (R12)
        end else begin
            q <= d;
        end
    end

    assign lines = q;
endmodule

// ### hw/pins_pkg.sv
package pins_pkg;

    localparam int NUM_CHAN = 2;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int OFS_W = 5;
    localparam int EV_W = 6;

    // Register word offsets inside one channel; address bit 5 picks the channel
    localparam logic [OFS_W-1:0] OFS_MODEM_CONTROL = 5'h00;
    localparam logic [OFS_W-1:0] OFS_ENH_FEATURE = 5'h04;
    localparam logic [OFS_W-1:0] OFS_INT_ENABLE = 5'h08;
    localparam logic [OFS_W-1:0] OFS_MODEM_STATUS = 5'h0C;
    localparam logic [OFS_W-1:0] OFS_EVENT_STATUS = 5'h10;
    localparam logic [OFS_W-1:0] OFS_EVENT_CLEAR = 5'h14;
    localparam logic [OFS_W-1:0] OFS_EVENT_ENABLE = 5'h18;
    localparam int CHAN_SEL_BIT = 5;

    // Field positions
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_AUX_BIT = 3;
    localparam int MCR_IR_BIT = 6;
    localparam int EFR_AUTO_RTS_BIT = 6;
    localparam int EFR_AUTO_CTS_BIT = 7;
    localparam int IER_RTS_BIT = 6;
    localparam int IER_CTS_BIT = 7;

    // Event status bit positions
    localparam int EV_CTS = 0;
    localparam int EV_DSR = 1;
    localparam int EV_CD = 2;
    localparam int EV_RI = 3;
    localparam int EV_CTS_STOP = 4;
    localparam int EV_RTS_STOP = 5;

    // Values after reset
    localparam logic [DATA_W-1:0] MCR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] EFR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IER_RESET = 8'h00;
    localparam logic [EV_W-1:0] EV_RESET = 6'h00;

    // Infrared timing in 16x sample ticks
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [3:0] IR_STRETCH_TICKS = 4'hF;

    // Reset pulse width
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [DATA_W-1:0] modem_control;
        logic [DATA_W-1:0] enhanced_feature;
        logic [DATA_W-1:0] interrupt_enable;
    } chan_ctrl_type;

    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } modem_in_type;

    typedef struct packed {
        logic [3:0] phase;
        logic [3:0] stretch;
        logic prev_tx;
        logic line_out;
        logic rx_bit;
    } codec_state_type;

    typedef struct packed {
        modem_in_type prev;
        logic rts_n;
        logic dtr_n;
        logic op2_n;
        logic irq_oe;
        logic tx_en;
        logic rdy_n;
        logic [EV_W-1:0] ev;
    } lines_state_type;

    typedef struct packed {
        chan_ctrl_type [NUM_CHAN-1:0] ctrl;
        logic [NUM_CHAN-1:0][EV_W-1:0] ev_stat;
        logic [NUM_CHAN-1:0][EV_W-1:0] ev_en;
        logic [NUM_CHAN-1:0] irq;
        logic [DATA_W-1:0] rdata;
    } regs_state_type;

    localparam codec_state_type CODEC_RESET = '{phase: 4'h0, stretch: 4'h0, prev_tx: 1'b1,
                                                line_out: 1'b1, rx_bit: 1'b1};
    localparam lines_state_type LINES_RESET = '{prev: 4'hF, rts_n: 1'b1, dtr_n: 1'b1, op2_n: 1'b1,
                                                irq_oe: 1'b0, tx_en: 1'b1, rdy_n: 1'b1, ev: 6'h00};

endpackage

// ### hw/uart_modem_serial_pins.sv
// Contract
// (R1) Infrared off: standard line, transmit idles high
// (R2) Infrared on: codec path, idle level low
// (R3) Peer holds receive line high when idle
// (R4) Aux bit one: interrupt driven, aux low
// (R5) Aux bit zero: interrupt floats, aux high
// (R6) Host avoids aux pin with interrupt used
// (R7) Host asserts request line before auto flow
// (R8) Clear-to-send gates transmit under auto flow
// (R9) Other modem inputs are status only
// (R10) Terminal-ready output under host control
// (R11) Receiver-ready output reflects receive data
// (R12) Reset clears registers, holds transmit high
// (R13) Channels controlled only by own registers
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module uart_modem_serial_pins
    import pins_pkg::*;
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [NUM_CHAN-1:0] tick16, // 16x bit-rate enables
    input wire logic [NUM_CHAN-1:0] tx_bit, // Transmit shifter bits
    output logic [NUM_CHAN-1:0] rx_bit, // Bits to receivers
    input wire logic [NUM_CHAN-1:0] rx_avail, // Receive data available
    input wire logic [NUM_CHAN-1:0] rx_halt, // Receive FIFO above trigger
    output logic [NUM_CHAN-1:0] tx_enable, // Transmit allowed
    output logic [NUM_CHAN-1:0] serial_out, // Transmit pins
    input wire logic [NUM_CHAN-1:0] serial_in, // Receive pins
    output logic [NUM_CHAN-1:0] request_to_send_n, // Request-to-send pins
    input wire logic [NUM_CHAN-1:0] clear_to_send_n, // Clear-to-send pins
    output logic [NUM_CHAN-1:0] terminal_ready_n, // Terminal-ready pins
    input wire logic [NUM_CHAN-1:0] set_ready_n, // Set-ready pins
    input wire logic [NUM_CHAN-1:0] carrier_detect_n, // Carrier-detect pins
    input wire logic [NUM_CHAN-1:0] ring_indicate_n, // Ring-indicate pins
    output logic [NUM_CHAN-1:0] aux_output_two_n, // Aux output two pins
    output logic [NUM_CHAN-1:0] channel_irq_out, // Interrupt pin level
    output logic [NUM_CHAN-1:0] channel_irq_oe, // Interrupt pin drive enable
    output logic [NUM_CHAN-1:0] rx_ready_n // Receiver-ready pins
);
    regs_state_type q, d;
    lines_state_type [NUM_CHAN-1:0] lines;
    modem_in_type [NUM_CHAN-1:0] modem_in;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input int chan,
                                     input logic [OFS_W-1:0] ofs);
        reg_hit = (addr[CHAN_SEL_BIT] == chan[0]) && (addr[OFS_W-1:0] == ofs);
    endfunction

    function automatic logic [DATA_W-1:0] ev_word(input logic [EV_W-1:0] ev);
        ev_word = {{(DATA_W-EV_W){1'b0}}, ev};
    endfunction

    // Register file and interrupt status
    always_comb begin
        d = q;
        d.rdata = 8'h00;
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (reg_wr && reg_hit(reg_addr, c, OFS_MODEM_CONTROL)) begin
                d.ctrl[c].modem_control = reg_wdata; // see (R13)
            end
            if (reg_wr && reg_hit(reg_addr, c, OFS_ENH_FEATURE)) begin
                d.ctrl[c].enhanced_feature = reg_wdata; // see (R13)
            end
            if (reg_wr && reg_hit(reg_addr, c, OFS_INT_ENABLE)) begin
                d.ctrl[c].interrupt_enable = reg_wdata; // see (R13)
            end
            if (reg_wr && reg_hit(reg_addr, c, OFS_EVENT_ENABLE)) begin
                d.ev_en[c] = reg_wdata[EV_W-1:0];
            end
            if (reg_wr && reg_hit(reg_addr, c, OFS_EVENT_CLEAR)) begin
                d.ev_stat[c] = q.ev_stat[c] & ~reg_wdata[EV_W-1:0];
            end
            // A new event wins over a clear in the same cycle
            d.ev_stat[c] = d.ev_stat[c] | lines[c].ev;
            d.irq[c] = |(d.ev_stat[c] & d.ev_en[c]);
            if (reg_rd) begin
                if (reg_hit(reg_addr, c, OFS_MODEM_CONTROL)) begin
                    d.rdata = q.ctrl[c].modem_control;
                end else if (reg_hit(reg_addr, c, OFS_ENH_FEATURE)) begin
                    d.rdata = q.ctrl[c].enhanced_feature;
                end else if (reg_hit(reg_addr, c, OFS_INT_ENABLE)) begin
                    d.rdata = q.ctrl[c].interrupt_enable;
                end else if (reg_hit(reg_addr, c, OFS_MODEM_STATUS)) begin
                    d.rdata = {4'h0, ~lines[c].prev.ri_n, ~lines[c].prev.cd_n,
                               ~lines[c].prev.dsr_n, ~lines[c].prev.cts_n}; // see (R9)
                end else if (reg_hit(reg_addr, c, OFS_EVENT_STATUS)) begin
                    d.rdata = ev_word(q.ev_stat[c]);
                end else if (reg_hit(reg_addr, c, OFS_EVENT_ENABLE)) begin
                    d.rdata = ev_word(q.ev_en[c]);
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                q.ctrl[c].modem_control <= MCR_RESET; // see (R12)
                q.ctrl[c].enhanced_feature <= EFR_RESET;
                q.ctrl[c].interrupt_enable <= IER_RESET;
                q.ev_stat[c] <= EV_RESET;
                q.ev_en[c] <= EV_RESET;
            end
            q.irq <= '0;
            q.rdata <= 8'h00;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign channel_irq_out = q.irq;

    // Independent pin logic per channel
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        assign modem_in[c] = '{cts_n: clear_to_send_n[c], dsr_n: set_ready_n[c],
                               cd_n: carrier_detect_n[c], ri_n: ring_indicate_n[c]};

        ir_codec u_codec (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ir_mode(q.ctrl[c].modem_control[MCR_IR_BIT]), // see (R1) see (R2) see (R13)
            .tick(tick16[c]),
            .tx_bit(tx_bit[c]),
            .line_in(serial_in[c]),
            .line_out(serial_out[c]),
            .rx_bit(rx_bit[c])
        );

        modem_lines u_lines (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ctrl(q.ctrl[c]), // see (R13)
            .modem_in(modem_in[c]),
            .rx_halt(rx_halt[c]),
            .rx_avail(rx_avail[c]),
            .lines(lines[c])
        );

        assign request_to_send_n[c] = lines[c].rts_n;
        assign terminal_ready_n[c] = lines[c].dtr_n;
        assign aux_output_two_n[c] = lines[c].op2_n;
        assign channel_irq_oe[c] = lines[c].irq_oe;
        assign tx_enable[c] = lines[c].tx_en;
        assign rx_ready_n[c] = lines[c].rdy_n;

        logic ir_on;
        logic aux_on;
        logic auto_cts;
        logic [3:0] zero_run;
        assign ir_on = q.ctrl[c].modem_control[MCR_IR_BIT];
        assign aux_on = q.ctrl[c].modem_control[MCR_AUX_BIT];
        assign auto_cts = q.ctrl[c].enhanced_feature[EFR_AUTO_CTS_BIT];

        // Counts ticks of an infrared zero bit for the pulse-width check
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                zero_run <= 4'h0;
            end else if (!ir_on || tx_bit[c] || $changed(tx_bit[c])) begin
                zero_run <= 4'h0;
            end else if (tick16[c]) begin
                zero_run <= zero_run + 4'h1;
            end
        end

        sequence s_aux_write;
            reg_wr && reg_hit(reg_addr, c, OFS_MODEM_CONTROL);
        endsequence

        sequence s_pins_follow_aux;
            ##2 (channel_irq_oe[c] == $past(reg_wdata[MCR_AUX_BIT], 2)) &&
                (aux_output_two_n[c] == !$past(reg_wdata[MCR_AUX_BIT], 2));
        endsequence

        a_std_tx_follow: assert property ( // see (R1)
            @(posedge sys_clk) disable iff (!rst_n)
            !ir_on && !$past(ir_on) ##1 !ir_on |-> serial_out[c] == $past(tx_bit[c]))
            else $error("standard transmit pin does not follow shifter");

        a_ir_idle_low: assert property ( // see (R2)
            @(posedge sys_clk) disable iff (!rst_n)
            (ir_on && tx_bit[c]) [*2] |=> !serial_out[c])
            else $error("infrared transmit not low when idle");

        a_ir_pulse_width: assert property ( // see (R2)
            @(posedge sys_clk) disable iff (!rst_n)
            ir_on && $past(ir_on) && !tx_bit[c] && zero_run >= 4'h4 |-> !serial_out[c])
            else $error("infrared pulse longer than three ticks");

        a_ir_rx_stretch: assert property ( // see (R2)
            @(posedge sys_clk) disable iff (!rst_n)
            ir_on && serial_in[c] ##1 ir_on |-> !rx_bit[c])
            else $error("infrared receive pulse not decoded as zero");

        a_aux_pins_pair: assert property ( // see (R4) see (R5)
            @(posedge sys_clk) disable iff (!rst_n)
            s_aux_write |-> s_pins_follow_aux)
            else $error("interrupt drive and aux pin disagree with control bit");

        a_aux_steady: assert property ( // see (R5)
            @(posedge sys_clk) disable iff (!rst_n)
            (!aux_on) [*2] |-> aux_output_two_n[c] && !channel_irq_oe[c])
            else $error("aux pin low or interrupt driven with control bit clear");

        a_cts_gate: assert property ( // see (R8)
            @(posedge sys_clk) disable iff (!rst_n)
            auto_cts && clear_to_send_n[c] |=> !tx_enable[c])
            else $error("transmit allowed while clear-to-send deasserted");

        a_cts_ignored: assert property ( // see (R8) see (R9)
            @(posedge sys_clk) disable iff (!rst_n)
            !auto_cts |=> tx_enable[c])
            else $error("transmit gated without automatic flow control");

        a_dtr_follow: assert property ( // see (R10)
            @(posedge sys_clk) disable iff (!rst_n)
            ##1 1'b1 |-> terminal_ready_n[c] == !$past(q.ctrl[c].modem_control[MCR_DTR_BIT]))
            else $error("terminal-ready pin does not follow control bit");

        a_rx_ready: assert property ( // see (R11)
            @(posedge sys_clk) disable iff (!rst_n)
            ##1 1'b1 |-> rx_ready_n[c] == !$past(rx_avail[c]))
            else $error("receiver-ready pin does not follow receive data");

        a_reset_tx_high: assert property ( // see (R12)
            @(posedge sys_clk)
            !rst_n |-> serial_out[c] && rx_bit[c] && request_to_send_n[c] && !channel_irq_oe[c])
            else $error("pins not at reset level during reset");

        a_event_set_wins: assert property (
            @(posedge sys_clk) disable iff (!rst_n)
            lines[c].ev[EV_CTS] |=> q.ev_stat[c][EV_CTS])
            else $error("event lost against clear");

        a_irq_level: assert property (
            @(posedge sys_clk) disable iff (!rst_n)
            ##1 1'b1 |-> channel_irq_out[c] == |(q.ev_stat[c] & q.ev_en[c]))
            else $error("interrupt level does not match enabled status");
    end

    a_read_window: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without read strobe");

    a_read_status: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_hit(reg_addr, 0, OFS_EVENT_STATUS) |=> reg_rdata == ev_word($past(q.ev_stat[0])))
        else $error("status read returns wrong value");
endmodule

// ### sim/line_peer.sv
`timescale 1ns/1ps
module line_peer
    import pins_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic [NUM_CHAN-1:0] ir_mode, // Infrared signalling
    input wire logic [NUM_CHAN-1:0] send_level, // Bit to send, 1 = mark
    input wire modem_in_type [NUM_CHAN-1:0] modem_set, // Wanted modem levels
    output logic [NUM_CHAN-1:0] serial_in, // Line into block
    output modem_in_type [NUM_CHAN-1:0] modem_out // Modem lines into block
);
    initial begin
        serial_in = '1;
        modem_out = '1;
    end
    always @(posedge sys_clk) begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            // Mark line idles high; infrared idles low, high for a zero
            serial_in[i] <= ir_mode[i] ^ send_level[i];
            modem_out[i] <= modem_set[i];
        end
    end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb
    import pins_pkg::*;
;
    logic sys_clk, rst_n, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [1:0] tick16, tx_bit, rx_bit, rx_avail, rx_halt, tx_enable, serial_out, serial_in;
    logic [1:0] request_to_send_n, clear_to_send_n, terminal_ready_n, set_ready_n;
    logic [1:0] carrier_detect_n, ring_indicate_n, aux_output_two_n, channel_irq_out;
    logic [1:0] channel_irq_oe, rx_ready_n, ir_cmd, send_level, tick_cnt;
    modem_in_type [1:0] modem_set, modem_out;
    int num_errors = 0;
    int n_compared = 0;

    uart_modem_serial_pins u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tick16(tick16), .tx_bit(tx_bit), .rx_bit(rx_bit), .rx_avail(rx_avail), .rx_halt(rx_halt),
        .tx_enable(tx_enable), .serial_out(serial_out), .serial_in(serial_in),
        .request_to_send_n(request_to_send_n), .clear_to_send_n(clear_to_send_n),
        .terminal_ready_n(terminal_ready_n), .set_ready_n(set_ready_n),
        .carrier_detect_n(carrier_detect_n), .ring_indicate_n(ring_indicate_n),
        .aux_output_two_n(aux_output_two_n), .channel_irq_out(channel_irq_out),
        .channel_irq_oe(channel_irq_oe), .rx_ready_n(rx_ready_n));
    line_peer u_peer (.sys_clk(sys_clk), .ir_mode(ir_cmd), .send_level(send_level),
        .modem_set(modem_set), .serial_in(serial_in), .modem_out(modem_out));
    assign clear_to_send_n = {modem_out[1].cts_n, modem_out[0].cts_n};
    assign set_ready_n = {modem_out[1].dsr_n, modem_out[0].dsr_n};
    assign carrier_detect_n = {modem_out[1].cd_n, modem_out[0].cd_n};
    assign ring_indicate_n = {modem_out[1].ri_n, modem_out[0].ri_n};

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        tick16 <= (tick_cnt == 2'h3) ? 2'h3 : 2'h0;
    end

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [ADDR_W-1:0] ra(input logic ch, input logic [OFS_W-1:0] o);
        return {ch, o};
    endfunction
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    task automatic reset_pins;
        check(8'(serial_out), 8'h03);
        check(8'(rx_bit), 8'h03);
        check(8'(terminal_ready_n), 8'h03);
        check(8'(aux_output_two_n), 8'h03);
        check(8'(channel_irq_oe), 8'h00);
        check(8'(request_to_send_n), 8'h03);
        check(8'(tx_enable), 8'h03);
        check(8'(rx_ready_n), 8'h03);
    endtask
    task automatic set_cts(input logic [1:0] v, input int n);
        @(posedge sys_clk);
        modem_set[0].cts_n <= v[0];
        modem_set[1].cts_n <= v[1];
        cyc(n);
    endtask

    initial begin
        #100000;
        num_errors++;
        final_report;
    end

    initial begin
        rst_n = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        tx_bit = 2'h3;
        {rx_avail, rx_halt, ir_cmd, tick_cnt, tick16} = '0;
        send_level = 2'h3;
        modem_set = '1;
        // Reset falls after time zero so every reset process sees the edge
        #1;
        rst_n = 1'b0;
        cyc(RESET_MIN_CYC);
        reset_pins;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(1);
        reset_pins;
        for (int c = 0; c < 2; c++) begin
            rd_chk(ra(c[0], OFS_MODEM_CONTROL), MCR_RESET);
            rd_chk(ra(c[0], OFS_ENH_FEATURE), EFR_RESET);
            rd_chk(ra(c[0], OFS_INT_ENABLE), IER_RESET);
        end
        rd_chk(ra(1'b0, 5'h1C), 8'h00);
        @(posedge sys_clk);
        tx_bit <= 2'h2;
        cyc(1);
        check(8'(serial_out), 8'h02);
        @(posedge sys_clk);
        tx_bit <= 2'h3;
        send_level <= 2'h1;
        cyc(2);
        check(8'(rx_bit), 8'h01);
        @(posedge sys_clk);
        send_level <= 2'h3;
        wr(ra(1'b0, OFS_MODEM_CONTROL), 8'h01);
        cyc(2);
        check(8'(terminal_ready_n), 8'h02);
        wr(ra(1'b1, OFS_MODEM_CONTROL), 8'h01);
        cyc(2);
        check(8'(terminal_ready_n), 8'h00);
        rd_chk(ra(1'b1, OFS_MODEM_CONTROL), 8'h01);
        wr(ra(1'b0, OFS_MODEM_CONTROL), 8'h08);
        cyc(2);
        check(8'(aux_output_two_n), 8'h02);
        check(8'(channel_irq_oe), 8'h01);
        wr(ra(1'b0, OFS_EVENT_CLEAR), 8'h3F);
        wr(ra(1'b0, OFS_EVENT_ENABLE), 8'h01);
        set_cts(2'h2, 5);
        rd_chk(ra(1'b0, OFS_EVENT_STATUS), 8'h01);
        check(8'(channel_irq_out), 8'h01);
        wr(ra(1'b0, OFS_EVENT_CLEAR), 8'h01);
        cyc(2);
        check(8'(channel_irq_out), 8'h00);
        wr(ra(1'b0, OFS_EVENT_ENABLE), 8'h10);
        set_cts(2'h3, 5);
        check(8'(channel_irq_out), 8'h00);
        rd_chk(ra(1'b0, OFS_EVENT_STATUS), 8'h01);
        wr(ra(1'b0, OFS_EVENT_CLEAR), 8'h3F);
        wr(ra(1'b0, OFS_ENH_FEATURE), 8'h80);
        wr(ra(1'b0, OFS_INT_ENABLE), 8'h80);
        cyc(2);
        check(8'(tx_enable), 8'h02);
        set_cts(2'h2, 3);
        check(8'(tx_enable), 8'h03);
        set_cts(2'h3, 5);
        check(8'(tx_enable), 8'h02);
        check(8'(channel_irq_out), 8'h01);
        rd_chk(ra(1'b0, OFS_EVENT_STATUS), 8'h11);
        wr(ra(1'b0, OFS_ENH_FEATURE), 8'h00);
        wr(ra(1'b0, OFS_EVENT_CLEAR), 8'h3F);
        // Request line asserted before auto flow goes on
        wr(ra(1'b0, OFS_MODEM_CONTROL), 8'h0A);
        wr(ra(1'b0, OFS_ENH_FEATURE), 8'h40);
        wr(ra(1'b0, OFS_INT_ENABLE), 8'h40);
        cyc(2);
        check(8'(request_to_send_n), 8'h02);
        @(posedge sys_clk);
        rx_halt <= 2'h1;
        cyc(4);
        check(8'(request_to_send_n), 8'h03);
        @(posedge sys_clk);
        rx_halt <= 2'h0;
        cyc(2);
        check(8'(request_to_send_n), 8'h02);
        rd_chk(ra(1'b0, OFS_EVENT_STATUS), 8'h20);
        @(posedge sys_clk);
        modem_set <= 8'h88;
        cyc(3);
        rd_chk(ra(1'b0, OFS_MODEM_STATUS), 8'h0E);
        check(8'({tx_enable, serial_out, rx_bit}), 8'h3F);
        @(posedge sys_clk);
        rx_avail <= 2'h2;
        cyc(2);
        check(8'(rx_ready_n), 8'h01);
        // Infrared on for channel 0; control write clears the aux bit, so the interrupt pin floats
        @(posedge sys_clk);
        ir_cmd <= 2'h1;
        wr(ra(1'b0, OFS_MODEM_CONTROL), 8'h40);
        cyc(3);
        check(8'(serial_out), 8'h02);
        @(posedge sys_clk);
        tx_bit <= 2'h2;
        cyc(2);
        check(8'(serial_out), 8'h03);
        cyc(16);
        check(8'(serial_out), 8'h02);
        @(posedge sys_clk);
        tx_bit <= 2'h3;
        cyc(80);
        check(8'(rx_bit), 8'h03);
        @(posedge sys_clk);
        send_level <= 2'h2;
        @(posedge sys_clk);
        send_level <= 2'h3;
        cyc(3);
        check(8'(rx_bit), 8'h02);
        cyc(64);
        check(8'(rx_bit), 8'h03);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cyc(2);
        reset_pins;
        cyc(RESET_MIN_CYC);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(ra(1'b0, OFS_MODEM_CONTROL), MCR_RESET);
        final_report;
    end
endmodule
